/* File: sfs_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module sfs_dev
	import sfs_pkg::*;
#(
	parameter int ERASE_CYC = SFS_ERASE_CYC
) (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	sfs_if.dev        lnk,
	input  wire logic [2:0] otp_lock_bits,
	output logic      busy,
	output logic      write_enable_latch
);
	typedef enum logic [2:0] {S_OP, S_ADDR, S_DUMMY, S_OUT, S_PDATA, S_IGN} sfs_ph_t;

	typedef struct packed {
		logic [2:0]  cs_s;
		logic [2:0]  ck_s;
		logic [2:0]  sin_s;
		sfs_ph_t     ph;
		logic [5:0]  cnt;
		logic [7:0]  op;
		logic [23:0] addr;
		logic [7:0]  shin;
		logic [7:0]  shout;
		logic [1:0]  idx;
		logic        erase_ok;
		logic        wlatch;
		logic        bsy;
		logic [31:0] tmr;
		logic [1:0]  ereg;
		logic        do_q;
		logic        oe_q;
	} sfs_dev_st_t;

	sfs_dev_st_t s_q, s_d;
	logic [7:0] mem [0:767];
	logic [7:0] table_rom [0:255];
	logic       wr_en;
	logic [9:0] wr_a;
	logic [7:0] wr_v;
	logic [9:0] clr_base;
	logic [9:0] clr_i;
	logic       clr_act;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [1:0] sel(input logic [23:0] a);
		sel = 2'd3; // 3 means not a register
		if (a[23:16] == 8'h00 && a[11:8] == 4'h0 && a[15:12] >= 4'h1 && a[15:12] <= 4'h3) begin
			sel = 2'(a[15:12] - 4'h1);
		end
	endfunction : sel

	function automatic logic [7:0] rd_byte(input logic [7:0] o, input logic [23:0] a,
		input logic [1:0] i);
		rd_byte = 8'h00;
		case (o)
			SFS_OP_ID: begin
				rd_byte = (i == 2'd0) ? SFS_MAKER_ID : (i == 2'd1) ? SFS_TYPE_ID : SFS_CAP_ID;
			end
			SFS_OP_TABLE: rd_byte = table_rom[a[7:0]];
			SFS_OP_READ: rd_byte = (sel(a) == 2'd3) ? 8'h00 : mem[{sel(a), a[7:0]}];
			SFS_OP_STATUS: begin
				// status bits sit at their own positions, the rest read zero
				rd_byte[SFS_BUSY_BIT]    = s_q.bsy;
				rd_byte[SFS_WRLATCH_BIT] = s_q.wlatch;
			end
			default: rd_byte = 8'h00;
		endcase
	endfunction : rd_byte

	// parameter table content is a simple fixed pattern
	for (genvar g = 0; g < 256; g++) begin : g_tab
		assign table_rom[g] = 8'(g ^ 8'h53);
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic rise;
		logic fall;
		logic [7:0] byte_in;
		logic [7:0] out_b;
		rise = 1'b0;
		fall = 1'b0;
		byte_in = 8'h00;
		out_b = rd_byte(s_q.op, s_q.addr, s_q.idx);
		s_d = s_q;
		wr_en = 1'b0;
		wr_a = 10'h000;
		wr_v = 8'h00;
		s_d.cs_s = {s_q.cs_s[1:0], lnk.cs_b};
		s_d.ck_s = {s_q.ck_s[1:0], lnk.sck};
		s_d.sin_s = {s_q.sin_s[1:0], lnk.serial_in_line};
		rise = s_q.ck_s[1] & ~s_q.ck_s[2];
		fall = ~s_q.ck_s[1] & s_q.ck_s[2];
		byte_in = {s_q.shin[6:0], s_q.sin_s[1]};
		// self-timed cycle runs regardless of the link
		if (s_q.bsy) begin
			if (s_q.tmr == 32'h0) begin
				s_d.bsy = 1'b0;
				s_d.wlatch = 1'b0;
			end else begin
				s_d.tmr = s_q.tmr - 32'h1;
			end
		end
		if (s_q.cs_s[1]) begin
			// deselect: only a cleanly ended erase starts
			if (!s_q.cs_s[2] && s_q.erase_ok) begin
				s_d.bsy = 1'b1;
				s_d.tmr = 32'(ERASE_CYC);
				s_d.ereg = sel(s_q.addr);
			end
			if (!s_q.cs_s[2] && s_q.ph == S_PDATA && s_q.idx != 2'd0) begin
				s_d.bsy = 1'b1; // program completion
				s_d.tmr = 32'(SFS_PROG_CYC);
				s_d.ereg = 2'd3;
			end
			s_d.ph = S_OP;
			s_d.cnt = 6'd0;
			s_d.erase_ok = 1'b0;
			s_d.oe_q = 1'b0;
			s_d.idx = 2'd0;
		end else if (rise) begin
			s_d.shin = byte_in;
			s_d.cnt = s_q.cnt + 6'd1;
			s_d.erase_ok = 1'b0; // any extra bit spoils it
			unique case (s_q.ph)
				S_OP: begin
					if (s_q.cnt == 6'd7) begin
						s_d.op = byte_in;
						s_d.cnt = 6'd0;
						s_d.ph = S_IGN;
						if (s_q.bsy) begin
							if (byte_in == SFS_OP_STATUS) begin
								s_d.ph = S_OUT;
							end
						end else if (byte_in == SFS_OP_WREN) begin
							s_d.wlatch = 1'b1;
						end else if (byte_in == SFS_OP_ID || byte_in == SFS_OP_STATUS) begin
							s_d.ph = S_OUT;
						end else if (byte_in == SFS_OP_TABLE || byte_in == SFS_OP_READ
							|| byte_in == SFS_OP_ERASE || byte_in == SFS_OP_PROG) begin
							s_d.ph = S_ADDR;
						end
					end
				end
				S_ADDR: begin
					s_d.addr = {s_q.addr[22:0], s_q.sin_s[1]};
					if (s_q.cnt == 6'(SFS_ADDR_BITS - 1)) begin
						s_d.cnt = 6'd0;
						s_d.ph = S_IGN;
						if (s_q.op == SFS_OP_ERASE) begin
							s_d.erase_ok = s_q.wlatch
								&& sel(s_d.addr) != 2'd3
								&& !otp_lock_bits[sel(s_d.addr)];
						end else if (s_q.op == SFS_OP_PROG) begin
							if (s_q.wlatch && sel(s_d.addr) != 2'd3
								&& !otp_lock_bits[sel(s_d.addr)]) begin
								s_d.ph = S_PDATA;
							end
						end else begin
							s_d.ph = S_DUMMY;
						end
					end
				end
				S_DUMMY: begin
					if (s_q.cnt == 6'(SFS_DUMMY_BITS - 1)) begin
						s_d.ph = S_OUT;
						s_d.cnt = 6'd0;
					end
				end
				S_PDATA: begin
					if (s_q.cnt == 6'd7) begin
						s_d.cnt = 6'd0;
						s_d.idx = 2'd1; // at least one byte taken
						wr_en = 1'b1;
						wr_a = {sel(s_q.addr), s_q.addr[7:0]};
						wr_v = byte_in;
						s_d.addr[7:0] = s_q.addr[7:0] + 8'd1; // page wraps inside register
					end
				end
				S_OUT, S_IGN: s_d.cnt = s_q.cnt;
			endcase
		end else if (fall && s_q.ph == S_OUT) begin
			// output shifts on falling edges, MSB first
			if (s_q.cnt == 6'd0) begin
				s_d.shout = {out_b[6:0], 1'b0};
				s_d.do_q = out_b[7];
				s_d.oe_q = 1'b1;
				s_d.cnt = 6'd1;
			end else begin
				s_d.do_q = s_q.shout[7];
				s_d.shout = {s_q.shout[6:0], 1'b0};
				s_d.cnt = (s_q.cnt == 6'd7) ? 6'd0 : s_q.cnt + 6'd1;
				if (s_q.cnt == 6'd7) begin
					s_d.addr[7:0] = s_q.addr[7:0] + 8'd1;
					if (s_q.op == SFS_OP_ID && s_q.idx != 2'd2) begin
						s_d.idx = s_q.idx + 2'd1;
					end
				end
			end
		end
	end

	// erase sweeps the chosen register to the erased value
	assign clr_act  = s_q.bsy && s_q.ereg != 2'd3 && s_q.tmr < 32'd256;
	assign clr_base = {s_q.ereg, 8'h00};
	assign clr_i    = clr_base | {2'b00, s_q.tmr[7:0]};

	always_ff @(posedge clk_sys) begin
		if (clr_act) begin
			mem[clr_i] <= SFS_ERASED;
		end else if (wr_en) begin
			mem[wr_a] <= mem[wr_a] & wr_v; // programming only clears bits
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.cs_s <= 3'b111;
			s_q.ereg <= 2'd3;
		end else begin
			s_q <= s_d;
		end
	end

	assign lnk.serial_out    = s_q.do_q;
	assign lnk.serial_out_oe = s_q.oe_q;
	assign busy              = s_q.bsy;
	assign write_enable_latch = s_q.wlatch;
endmodule : sfs_dev
`default_nettype wire

/* File: sfs_pkg.sv */
`default_nettype none
package sfs_pkg;
	// ************************************************************
	// opcodes
	// ************************************************************
	localparam logic [7:0] SFS_OP_ID      = 8'h9f;
	localparam logic [7:0] SFS_OP_TABLE   = 8'h5a;
	localparam logic [7:0] SFS_OP_ERASE   = 8'h44;
	localparam logic [7:0] SFS_OP_PROG    = 8'h42;
	localparam logic [7:0] SFS_OP_READ    = 8'h48;
	localparam logic [7:0] SFS_OP_WREN    = 8'h06;
	localparam logic [7:0] SFS_OP_STATUS  = 8'h05;
	// ************************************************************
	// identity (values arbitrary) and layout
	// ************************************************************
	localparam logic [7:0] SFS_MAKER_ID   = 8'h5c;
	localparam logic [7:0] SFS_TYPE_ID    = 8'h31;
	localparam logic [7:0] SFS_CAP_ID     = 8'h13;
	localparam int         SFS_ADDR_BITS  = 24;
	localparam int         SFS_DUMMY_BITS = 8;
	localparam int         SFS_BUSY_BIT   = 0;
	localparam int         SFS_WRLATCH_BIT = 1;
	localparam logic [7:0] SFS_ERASED     = 8'hff;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int         SFS_CLK_NS     = 5;
	localparam int         SFS_ERASE_US   = 100;
	localparam int         SFS_ERASE_CYC  = SFS_ERASE_US * 1000 / SFS_CLK_NS;
	localparam int         SFS_PROG_CYC   = 64;
	localparam int         SFS_SCK_HALF   = 16;
endpackage : sfs_pkg
`default_nettype wire

/* File: sfs_if.sv */
`timescale 1ns/1ps
`default_nettype none
// serial link between host and device
interface sfs_if;
	logic cs_b;
	logic sck;
	logic serial_in_line;
	logic serial_out;
	logic serial_out_oe;
	modport dev (input cs_b, input sck, input serial_in_line,
		output serial_out, output serial_out_oe);
	modport host (output cs_b, output sck, output serial_in_line,
		input serial_out, input serial_out_oe);
endinterface : sfs_if
`default_nettype wire

/* File: sfs_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sfs_host
	import sfs_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	sfs_if.host              lnk,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [7:0]  cmd_op,
	input  wire logic [23:0] cmd_addr,
	input  wire logic [8:0]  cmd_len,
	input  wire logic [7:0]  wr_data,
	input  wire logic        wr_valid,
	output logic             wr_ready,
	output logic [7:0]       rd_data,
	output logic             rd_valid,
	input  wire logic        rd_ready
);
	typedef enum logic [2:0] {H_IDLE, H_OP, H_ADDR, H_DUMMY, H_DATA, H_END} sfs_hph_t;

	typedef struct packed {
		sfs_hph_t    ph;
		logic [7:0]  div;
		logic        sck;
		logic        cs_b;
		logic        mosi;
		logic [5:0]  bit_n;
		logic [7:0]  op;
		logic [31:0] sh;
		logic [8:0]  left;
		logic [2:0]  so_s;
		logic [7:0]  rx;
		logic [1:0]  b_cnt;
		logic [15:0] b_dat;
	} sfs_host_st_t;

	sfs_host_st_t s_q, s_d;
	logic is_wr;
	logic has_addr;
	logic has_dummy;
	logic edge_now;
	logic stall;

	// ************************************************************
	// sequencing; the clock is divided from clk_sys
	// ************************************************************
	always_comb begin
		s_d = s_q;
		cmd_ready = (s_q.ph == H_IDLE);
		wr_ready = 1'b0;
		is_wr = (s_q.op == SFS_OP_PROG);
		has_addr = (s_q.op == SFS_OP_PROG || s_q.op == SFS_OP_ERASE
			|| s_q.op == SFS_OP_READ || s_q.op == SFS_OP_TABLE);
		has_dummy = (s_q.op == SFS_OP_READ || s_q.op == SFS_OP_TABLE);
		edge_now = (s_q.div == 8'(SFS_SCK_HALF - 1));
		// a full buffer halts the clock so no word is lost
		stall = (s_q.b_cnt == 2'd2) || (is_wr && s_q.ph == H_DATA && s_q.bit_n == 6'd0
			&& !s_q.sck && !wr_valid);
		s_d.so_s = {s_q.so_s[1:0], lnk.serial_out};
		if (rd_ready && s_q.b_cnt != 2'd0) begin
			s_d.b_dat = {8'h00, s_q.b_dat[15:8]};
			s_d.b_cnt = s_q.b_cnt - 2'd1;
		end
		if (s_q.ph == H_IDLE) begin
			s_d.cs_b = 1'b1;
			if (cmd_valid) begin
				s_d.op = cmd_op;
				s_d.sh = {cmd_op, cmd_addr};
				s_d.left = cmd_len;
				s_d.ph = H_OP;
				s_d.cs_b = 1'b0;
				s_d.bit_n = 6'd0;
				s_d.div = 8'h00;
				s_d.mosi = cmd_op[7];
			end
		end else if (s_q.ph == H_END) begin
			s_d.cs_b = 1'b1;
			s_d.ph = H_IDLE;
		end else if (!stall) begin
			s_d.div = edge_now ? 8'h00 : s_q.div + 8'h01;
			if (edge_now) begin
				s_d.sck = ~s_q.sck;
				if (!s_q.sck) begin
					// rising edge: sample device output
					s_d.rx = {s_q.rx[6:0], s_q.so_s[1]};
					if (s_q.ph == H_DATA && is_wr && s_q.bit_n == 6'd0) begin
						wr_ready = 1'b1;
					end
				end else begin
					// falling edge: advance bit and present next
					s_d.bit_n = s_q.bit_n + 6'd1;
					s_d.sh = {s_q.sh[30:0], 1'b0};
					s_d.mosi = s_q.sh[30];
					unique case (s_q.ph)
						H_OP: if (s_q.bit_n == 6'd7) begin
							s_d.bit_n = 6'd0;
							s_d.ph = has_addr ? H_ADDR : (s_q.left != 9'd0 ? H_DATA : H_END);
						end
						H_ADDR: if (s_q.bit_n == 6'(SFS_ADDR_BITS - 1)) begin
							s_d.bit_n = 6'd0;
							s_d.ph = has_dummy ? H_DUMMY : (is_wr ? H_DATA : H_END);
						end
						H_DUMMY: if (s_q.bit_n == 6'(SFS_DUMMY_BITS - 1)) begin
							s_d.bit_n = 6'd0;
							s_d.ph = H_DATA;
						end
						H_DATA: if (s_q.bit_n == 6'd7) begin
							s_d.bit_n = 6'd0;
							s_d.left = s_q.left - 9'd1;
							if (s_q.left == 9'd1) begin
								s_d.ph = H_END;
							end
							if (!is_wr) begin
								s_d.b_dat[8*s_d.b_cnt[0] +: 8] = s_q.rx;
								s_d.b_cnt = s_d.b_cnt + 2'd1;
							end
						end
						default: s_d.ph = H_END;
					endcase
				end
			end
		end
		// a write byte is loaded into the shifter when accepted
		if (wr_ready) begin
			s_d.sh[31:24] = wr_data;
		end
		if (s_q.ph == H_DATA && is_wr && s_q.bit_n == 6'd0 && !s_q.sck && wr_valid) begin
			s_d.mosi = wr_data[7];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.cs_b <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign lnk.cs_b           = s_q.cs_b;
	assign lnk.sck            = s_q.sck;
	assign lnk.serial_in_line = s_q.mosi;
	assign rd_data            = s_q.b_dat[7:0];
	assign rd_valid           = (s_q.b_cnt != 2'd0);
endmodule : sfs_host
`default_nettype wire

/* File: sfs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// link checker
// ********
module sfs_assertions
	import sfs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic cs_b,
	input wire logic sck,
	input wire logic serial_in_line,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic busy,
	input wire logic write_enable_latch
);
	logic [15:0] bcnt_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// length of the busy stretch, used to tell erase from program
	always_ff @(posedge clk_sys) begin
		if (!rst_b || !busy) bcnt_q <= 16'h0000;
		else bcnt_q <= bcnt_q + 16'h0001;
	end
	sequence s_end; $rose(cs_b); endsequence
	sequence s_drop; ##[0:8] !serial_out_oe; endsequence
	property p_release; s_end |-> s_drop; endproperty
	a_release: assert property (p_release) else $error("output driven after frame");
	property p_oe_frame; $rose(serial_out_oe) |-> !cs_b; endproperty
	a_oe_frame: assert property (p_oe_frame) else $error("output driven unselected");
	// data moves after falling edges, so it is steady past each rise
	property p_out_hold; $rose(sck) && serial_out_oe |=> $stable(serial_out) [*8]; endproperty
	a_out_hold: assert property (p_out_hold) else $error("output moved near rising edge");
	property p_in_hold; $rose(sck) |=> $stable(serial_in_line) [*4]; endproperty
	a_in_hold: assert property (p_in_hold) else $error("input moved near rising edge");
	property p_sck_idle; cs_b [*4] |-> !sck; endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("clock runs outside frame");
	// the device sees the select rise three clocks late, and the host may
	// already open the next frame, so look at the select as it was then
	property p_busy_cause; $rose(busy) |-> $past(cs_b, 3) && $past(write_enable_latch); endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without latch");
	property p_busy_hold; $rose(busy) |-> busy [*8]; endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
	// program time is fixed, so a longer stretch is an erase
	property p_wel_clr;
		$fell(busy) && bcnt_q > 16'(SFS_PROG_CYC * 2) |-> ##[0:2] !write_enable_latch;
	endproperty
	a_wel_clr: assert property (p_wel_clr) else $error("latch kept after erase");
	property p_busy_min; $fell(busy) |-> bcnt_q >= 16'(SFS_PROG_CYC - 2); endproperty
	a_busy_min: assert property (p_busy_min) else $error("cycle ended early");
endmodule : sfs_assertions
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// bench top
// ********
module testbench
	import sfs_pkg::*;
;
	localparam int ERA = 8000;
	localparam logic [23:0] BAD [4] = '{24'h001000, 24'h001100, 24'h004000, 24'h011000};
	logic        clk_sys, rst_b, cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, rd_ready;
	logic [7:0]  cmd_op, wr_data, rd_data;
	logic [23:0] cmd_addr;
	logic [8:0]  cmd_len;
	logic [2:0]  lock;
	logic        busy, wlat, busy2, wlat2, oe_seen;
	logic [39:0] acc;
	logic [31:0] din_q, dout_q;
	int          n_mismatch, check_count, n_sck, bdur, b0;
	sfs_if lnk ();
	sfs_if l2 ();
	sfs_host sfs_host_i (.clk_sys(clk_sys), .rst_b(rst_b), .lnk(lnk), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
		.wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
		.rd_valid(rd_valid), .rd_ready(rd_ready));
	sfs_dev #(.ERASE_CYC(ERA)) sfs_dev_i (.clk_sys(clk_sys), .rst_b(rst_b), .lnk(lnk),
		.otp_lock_bits(lock), .busy(busy), .write_enable_latch(wlat));
	// second end, fed by a bench driver that breaks framing
	sfs_dev #(.ERASE_CYC(ERA)) sfs_dev_bad_i (.clk_sys(clk_sys), .rst_b(rst_b), .lnk(l2),
		.otp_lock_bits(3'h0), .busy(busy2), .write_enable_latch(wlat2));
	sfs_assertions sfs_assertions_i (.clk_sys(clk_sys), .rst_b(rst_b), .cs_b(lnk.cs_b),
		.sck(lnk.sck), .serial_in_line(lnk.serial_in_line), .serial_out(lnk.serial_out),
		.serial_out_oe(lnk.serial_out_oe), .busy(busy), .write_enable_latch(wlat));
	// 200 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// frame watch on the joined link
	always @(negedge lnk.cs_b) begin
		n_sck = 0;
		oe_seen = 1'b0;
	end
	always @(posedge lnk.serial_out_oe) oe_seen = 1'b1;
	always @(posedge lnk.sck) begin
		n_sck++;
		din_q = {din_q[30:0], lnk.serial_in_line};
		dout_q = {dout_q[30:0], lnk.serial_out};
	end
	always @(posedge clk_sys) if (busy === 1'b1) bdur <= bdur + 1;
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test
	// one command; st stalls the reader 32 of every 64 cycles, too short for the two-entry buffer to fill
	task automatic xfer(input logic [7:0] op, input logic [23:0] ad, input int nr,
		input int nw, input logic st);
		int k = 0;
		int w = 0;
		int c;
		acc = '0;
		@(posedge clk_sys);
		cmd_op <= op;
		cmd_addr <= ad;
		cmd_len <= 9'(nr + nw);
		cmd_valid <= 1'b1;
		wr_data <= 8'h05;
		wr_valid <= (nw > 0);
		for (c = 0; c < 400; c++) begin
			@(negedge clk_sys);
			if (cmd_ready === 1'b1) break;
		end
		if (cmd_ready !== 1'b1) n_mismatch++;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		for (c = 0; c < 30000 && (k < nr || w < nw); c++) begin
			@(negedge clk_sys);
			if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
				acc = {acc[31:0], rd_data};
				k++;
			end
			if (wr_valid === 1'b1 && wr_ready === 1'b1) w++;
			@(posedge clk_sys);
			rd_ready <= !st || c[5];
			wr_data <= 8'(w * 3 + 5);
			wr_valid <= (w < nw);
		end
		// the frame is over only once the host is back in idle
		@(negedge clk_sys);
		for (c = 0; c < 2000 && cmd_ready !== 1'b1; c++) @(negedge clk_sys);
		if (cmd_ready !== 1'b1 || k < nr || w < nw) n_mismatch++;
	endtask : xfer
	task automatic wren();
		xfer(SFS_OP_WREN, 24'h000000, 0, 0, 1'b0);
	endtask : wren
	task automatic settle();
		int c;
		repeat (16) @(posedge clk_sys);
		for (c = 0; c < 20000 && busy !== 1'b0; c++) @(posedge clk_sys);
		if (busy !== 1'b0) n_mismatch++;
	endtask : settle
	// raw frame on the second link at a 160 ns clock
	task automatic raw(input logic [63:0] v, input int n);
		@(posedge clk_sys);
		l2.cs_b <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			l2.serial_in_line <= v[i];
			repeat (16) @(posedge clk_sys);
			l2.sck <= 1'b1;
			repeat (16) @(posedge clk_sys);
			l2.sck <= 1'b0;
		end
		repeat (16) @(posedge clk_sys);
		l2.cs_b <= 1'b1;
		l2.serial_in_line <= ~v[0];
		repeat (64) @(posedge clk_sys);
	endtask : raw
	// hang guard, well past the expected run
	initial begin
		#400000;
		n_mismatch++;
		finish_test();
	end
	// ********
	// test sequence
	// ********
	initial begin
		rst_b = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 8'h00;
		cmd_addr = 24'h000000;
		cmd_len = 9'h000;
		wr_data = 8'h00;
		wr_valid = 1'b0;
		rd_ready = 1'b1;
		lock = 3'h0;
		oe_seen = 1'b0;
		n_mismatch = 0;
		check_count = 0;
		bdur = 0;
		l2.cs_b = 1'b1;
		l2.sck = 1'b0;
		l2.serial_in_line = 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		xfer(SFS_OP_ID, 24'h000000, 3, 0, 1'b0);
		chk(acc[23:0], {SFS_MAKER_ID, SFS_TYPE_ID, SFS_CAP_ID});
		chk(dout_q[23:0], {SFS_MAKER_ID, SFS_TYPE_ID, SFS_CAP_ID});
		$display("id test end");
		xfer(SFS_OP_TABLE, 24'h0000f0, 5, 0, 1'b1);
		chk(acc, 40'ha3a2a1a0a7);
		chk(n_sck, 80);
		$display("table test end");
		// first lacks the latch, the rest have bad addresses
		for (int i = 0; i < 4; i++) begin
			if (i == 1) wren();
			b0 = bdur;
			xfer(SFS_OP_ERASE, BAD[i], 0, 0, 1'b0);
			settle();
			chk(bdur - b0, 0);
		end
		chk(wlat, 1'b1);
		lock <= 3'b010;
		b0 = bdur;
		xfer(SFS_OP_ERASE, 24'h002000, 0, 0, 1'b0);
		xfer(SFS_OP_PROG, 24'h002000, 0, 1, 1'b0);
		settle();
		chk(bdur - b0, 0);
		$display("refusal test end");
		b0 = bdur;
		xfer(SFS_OP_ERASE, 24'h001000, 0, 0, 1'b0);
		chk(din_q, {SFS_OP_ERASE, 24'h001000});
		xfer(SFS_OP_STATUS, 24'h000000, 1, 0, 1'b0);
		chk(acc[1:0], 2'b11);
		xfer(SFS_OP_READ, 24'h001000, 1, 0, 1'b0);
		chk(oe_seen, 1'b0);
		chk(busy, 1'b1);
		settle();
		chk(bdur - b0 >= ERA, 1'b1);
		chk(wlat, 1'b0);
		$display("erase test end");
		wren();
		b0 = bdur;
		xfer(SFS_OP_PROG, 24'h0010fe, 0, 4, 1'b0);
		chk(n_sck, 64);
		settle();
		chk(bdur > b0, 1'b1);
		xfer(SFS_OP_READ, 24'h0010fe, 5, 0, 1'b1);
		chk(acc, 40'h05080b0eff);
		chk(n_sck, 80);
		$display("program test end");
		raw(64'h06, 8);
		raw({31'h0, SFS_OP_ERASE, 24'h001000, 1'b0}, 33);
		chk(busy2, 1'b0);
		chk(wlat2, 1'b1);
		raw({32'h0, SFS_OP_ERASE, 24'h001000}, 32);
		chk(busy2, 1'b1);
		$display("framing test end");
		finish_test();
	end
endmodule : testbench
`default_nettype wire
